// [verilog/tei_pkg.sv]
package tei_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] TEI_SECT_EN_OFF = 8'h01;
  localparam logic [7:0] TEI_BLK_IRQ_EN_OFF = 8'h20;
  localparam logic [7:0] TEI_BLK_IRQ_ST_OFF = 8'h21;

  // ==========================================================
  // field positions and reset values
  localparam int TEI_NUM_CH = 3;
  localparam int TEI_NUM_TX = 2;
  localparam int TEI_SECT_TX_LSB = 0;
  localparam int TEI_SECT_RX_LSB = 4;
  localparam logic [7:0] TEI_SECT_EN_RST = 8'h00;
  localparam logic [2:0] TEI_BLK_IRQ_EN_RST = 3'h0;
  localparam logic [2:0] TEI_BLK_IRQ_ST_RST = 3'h0;
  localparam logic [7:0] TEI_SECT_EN_MASK = 8'h77;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tei_reg_req_type;

  typedef struct packed {
    logic pos;
    logic neg;
    logic oe_n;
  } tei_line_type;

endpackage

// [verilog/tei_pin_sync.sv]
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves only when stages two and three agree
module tei_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) begin
      $error("tei_pin_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// [verilog/tei_block.sv]
`timescale 1ns/100ps
// How it works
// - channel 1 driver bit resets 0; 1 drives pulses while its synchronised driver pin is high, 0 tri-states both line outputs
// - channel 0 driver bit resets 0; 1 drives pulses while its synchronised driver pin is high, 0 tri-states both line outputs
// - block interrupt enable at 0x20: bits 2..0 read/write reset 0, 7..3 read zero
// - a channel with block enable 0 raises no interrupt at all
// - a cause requests interrupt only with source enable and block enable both set
// - channel 1 and 0 enable bits gate their channel like the channel 2 bit
// - status flag per channel set when pending, cleared after source status read
module tei_block
  import tei_pkg::*;
#(
  parameter int NUM_TX = TEI_NUM_TX
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire tei_reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [TEI_NUM_CH-1:0] src_irq_i,
  input wire logic [TEI_NUM_CH-1:0] src_status_read_i,
  input wire logic [NUM_TX-1:0] driver_on_pin_i,
  input wire logic [NUM_TX-1:0] tx_pos_i,
  input wire logic [NUM_TX-1:0] tx_neg_i,
  output tei_line_type [NUM_TX-1:0] line_o,
  output logic [2:0] rx_section_on_o,
  output logic irq_o
);

  logic [7:0] sect_en_q;
  logic [2:0] blk_en_q;
  logic [2:0] pend_q;
  logic [NUM_TX-1:0] pin_on;
  logic [NUM_TX-1:0] tx_active;
  logic wr_sect;
  logic wr_blk_en;

  initial begin
    if (NUM_TX != TEI_NUM_TX) begin
      $error("tei_block: NUM_TX must equal the two software-driven channels");
    end
  end

  // ==========================================================
  // register writes
  assign wr_sect = reg_req_i.wr && (reg_req_i.addr == TEI_SECT_EN_OFF);
  assign wr_blk_en = reg_req_i.wr && (reg_req_i.addr == TEI_BLK_IRQ_EN_OFF);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sect_en_q <= TEI_SECT_EN_RST;
    end else if (wr_sect) begin
      sect_en_q <= reg_req_i.wdata & TEI_SECT_EN_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_en_q <= TEI_BLK_IRQ_EN_RST;
    end else if (wr_blk_en) begin
      blk_en_q <= reg_req_i.wdata[2:0];
    end
  end

  // ==========================================================
  // register reads; unmapped offsets and reserved bits read zero
  // upper bits zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        TEI_SECT_EN_OFF: reg_rdata_o <= sect_en_q;
        TEI_BLK_IRQ_EN_OFF: reg_rdata_o <= {5'h00, blk_en_q};
        TEI_BLK_IRQ_ST_OFF: reg_rdata_o <= {5'h00, pend_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign rx_section_on_o = sect_en_q[TEI_SECT_RX_LSB +: 3];

  // ==========================================================
  // transmit drivers
  tei_pin_sync #(
    .WIDTH(NUM_TX)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(driver_on_pin_i),
    .level_o(pin_on)
  );

  assign tx_active = sect_en_q[TEI_SECT_TX_LSB +: NUM_TX] & pin_on;

  genvar g;
  generate
    for (g = 0; g < NUM_TX; g++) begin : gen_tx
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          line_o[g] <= '{pos: 1'b0, neg: 1'b0, oe_n: 1'b1};
        end else begin
          line_o[g].pos <= tx_active[g] & tx_pos_i[g];
          line_o[g].neg <= tx_active[g] & tx_neg_i[g];
          line_o[g].oe_n <= ~tx_active[g];
        end
      end

      driver_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !tx_active[g] |=> line_o[g].oe_n && !line_o[g].pos && !line_o[g].neg)
        else $error("disabled driver still drives the line");
      pin_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !pin_on[g] |=> line_o[g].oe_n)
        else $error("driver on while enable pin is low");
      driver_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_active[g] |=> !line_o[g].oe_n && (line_o[g].pos == $past(tx_pos_i[g])))
        else $error("enabled driver not driving the line");
    end
  endgenerate

  // ==========================================================
  // block-level pending flags; a set wins over a clear
  // both enables needed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= TEI_BLK_IRQ_ST_RST;
    end else begin
      pend_q <= (src_irq_i & blk_en_q) | (pend_q & ~src_status_read_i);
    end
  end

  assign irq_o = |(pend_q & blk_en_q);

  // ==========================================================
  // checks
  sequence blk_en_wr_s;
    wr_blk_en ##1 (reg_req_i.rd && reg_req_i.addr == TEI_BLK_IRQ_EN_OFF);
  endsequence

  en_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    blk_en_wr_s |=> reg_rdata_o == {5'h00, $past(reg_req_i.wdata[2:0], 2)})
    else $error("block enable readback mismatch");

  no_irq_disabled_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((pend_q & blk_en_q) == 3'h0) |-> !irq_o)
    else $error("interrupt raised for a disabled channel");

  pend_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_irq_i[0] && blk_en_q[0]) |=> pend_q[0])
    else $error("enabled cause did not set pending flag");

  pend_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!blk_en_q[1] && !pend_q[1]) |=> !pend_q[1])
    else $error("pending set while channel disabled");

  pend_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pend_q[2] && !src_status_read_i[2]) |=> pend_q[2])
    else $error("pending flag cleared without a status read");

  irq_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_irq_i[2] && blk_en_q[2] && !wr_blk_en) |=> irq_o)
    else $error("interrupt output missing for enabled pending channel");

  // ==========================================================
  // status and reserved-bit reads
  sequence st_read_s;
    reg_req_i.rd && (reg_req_i.addr == TEI_BLK_IRQ_ST_OFF);
  endsequence

  st_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_read_s |=> reg_rdata_o == {5'h00, $past(pend_q)})
    else $error("block status readback mismatch");

  en_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_req_i.rd && reg_req_i.addr == TEI_BLK_IRQ_EN_OFF) |=> reg_rdata_o[7:3] == 5'h00)
    else $error("reserved block enable bits read nonzero");

  // ==========================================================
  // per-channel interrupt checks; each channel must obey the same gates
  genvar c;
  generate
    for (c = 0; c < TEI_NUM_CH; c++) begin : gen_irq_chk
      sequence cause_taken_s;
        src_irq_i[c] && blk_en_q[c];
      endsequence

      // a read in the same cycle as a new cause must not clear it
      sequence clear_only_s;
        pend_q[c] && src_status_read_i[c] && !(src_irq_i[c] && blk_en_q[c]);
      endsequence

      ch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cause_taken_s |=> pend_q[c])
        else $error("enabled channel cause did not set its pending flag");

      ch_blocked_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!blk_en_q[c] && !pend_q[c]) |=> !pend_q[c])
        else $error("pending flag set on a channel with block enable off");

      ch_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clear_only_s |=> !pend_q[c])
        else $error("pending flag not cleared by the status read");

      ch_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pend_q[c] && blk_en_q[c]) |-> irq_o)
        else $error("enabled pending channel not requesting an interrupt");
    end
  endgenerate

endmodule

// [tb/tb_tei_block.sv]
`timescale 1ns/100ps
module tb_tei_block;
  import tei_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  tei_reg_req_type req = '0;
  logic [7:0] rdata;
  logic [2:0] src_irq = 3'h0, src_rd = 3'h0, rx_on;
  logic [1:0] pin = 2'h3, tx_pos = 2'h3, tx_neg = 2'h2;
  tei_line_type [1:0] line;
  logic irq;
  int num_errors = 0;
  int checks_done = 0;
  // ==========================================================
  // device under test
  tei_block u_tei_block (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .src_irq_i(src_irq), .src_status_read_i(src_rd), .driver_on_pin_i(pin), .tx_pos_i(tx_pos),
    .tx_neg_i(tx_neg), .line_o(line), .rx_section_on_o(rx_on), .irq_o(irq));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========================================================
  // shared tasks
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask
  // read data is registered, so it is settled by the falling edge after the strobe
  task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_i);
    req.rd = 1'b0;
    chk(nm, rdata, exp);
  endtask
  task pulse(input bit clr, input int c);
    @(negedge clk_i);
    if (clr) src_rd[c] = 1'b1;
    else src_irq[c] = 1'b1;
    @(negedge clk_i);
    src_rd = 3'h0;
    src_irq = 3'h0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    rchk("blk_en", 8'h20, 8'h00);
    rchk("sect_en", 8'h01, 8'h00);
    chk("line0", {5'h00, line[0]}, 8'h01);
    chk("line1", {5'h00, line[1]}, 8'h01);
    chk("rx_on", {5'h00, rx_on}, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    $display("test reset done");
  endtask
  task t_regs;
    wr(8'h20, 8'hff);
    rchk("blk_en", 8'h20, 8'h07);
    wr(8'h21, 8'hff);
    rchk("blk_st", 8'h21, 8'h00);
    rchk("unmapped", 8'h7f, 8'h00);
    wr(8'h01, 8'hff);
    rchk("sect_en", 8'h01, 8'h77);
    chk("rx_on", {5'h00, rx_on}, 8'h07);
    wr(8'h01, 8'h00);
    // write then read in the very next cycle
    @(negedge clk_i);
    req = '{addr: 8'h20, wdata: 8'h05, wr: 1'b1, rd: 1'b0};
    @(negedge clk_i);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge clk_i);
    req.rd = 1'b0;
    chk("blk_en", rdata, 8'h05);
    wr(8'h20, 8'h00);
    rchk("blk_en", 8'h20, 8'h00);
    $display("test regs done");
  endtask
  task t_driver;
    wr(8'h01, 8'h02);
    repeat (2) @(negedge clk_i);
    chk("line1", {5'h00, line[1]}, 8'h06);
    chk("line0", {5'h00, line[0]}, 8'h01);
    wr(8'h01, 8'h03);
    pin = 2'h1;
    // pin passes a synchroniser, so allow it several cycles
    repeat (6) @(negedge clk_i);
    chk("line1", {5'h00, line[1]}, 8'h01);
    chk("line0", {5'h00, line[0]}, 8'h04);
    pin = 2'h2;
    repeat (6) @(negedge clk_i);
    chk("line0", {5'h00, line[0]}, 8'h01);
    chk("line1", {5'h00, line[1]}, 8'h06);
    pin = 2'h3;
    wr(8'h01, 8'h00);
    repeat (2) @(negedge clk_i);
    chk("line1", {5'h00, line[1]}, 8'h01);
    $display("test driver done");
  endtask
  task t_irq;
    for (int c = 0; c < 3; c++) begin
      pulse(1'b0, c);
      chk("irq", {7'h00, irq}, 8'h00);
      rchk("blk_st", 8'h21, 8'h00);
      wr(8'h20, 8'(8'h01 << c));
      pulse(1'b0, c);
      chk("irq", {7'h00, irq}, 8'h01);
      rchk("blk_st", 8'h21, 8'(8'h01 << c));
      wr(8'h20, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      rchk("blk_st", 8'h21, 8'(8'h01 << c));
      pulse(1'b1, c);
      rchk("blk_st", 8'h21, 8'h00);
    end
    $display("test irq done");
  endtask
  // ==========================================================
  // sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_regs();
    t_driver();
    t_irq();
    close_out();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
endmodule
